// ### hw/elapsed_timers_pkg.sv
// Purpose: shared constants and types for the power-on elapsed-time counters
// Assumes: 40 MHz clock, Avalon-MM slave with 32-bit data and byte addresses
// Notes: register index times four gives the byte address
// Summary of operation
// - main and standby 32-bit counters advance once per powered second
// - main count read as four bytes at index 10h to 13h, low first
// - standby count read as bytes from index 14h upward, low first
// - reading either lowest byte freezes all four copies of that counter
// - reading either highest byte resumes copy updating for that counter
// - byte copies reset to zero and ignore software writes
// - writing a clear bit zeroes its counter; the bit reads zero
// - set lock bit blocks writes to clear bits and itself until reset
package elapsed_timers_pkg;

    // ------------------------------------------------------------
    // register map (indices; byte address is index * 4)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] MAIN_B0_IDX = 6'h10;
    localparam logic [IDX_W-1:0] MAIN_B1_IDX = 6'h11;
    localparam logic [IDX_W-1:0] MAIN_B2_IDX = 6'h12;
    localparam logic [IDX_W-1:0] MAIN_B3_IDX = 6'h13;
    localparam logic [IDX_W-1:0] STBY_B0_IDX = 6'h14;
    localparam logic [IDX_W-1:0] STBY_B1_IDX = 6'h15;
    localparam logic [IDX_W-1:0] STBY_B2_IDX = 6'h16;
    localparam logic [IDX_W-1:0] STBY_B3_IDX = 6'h17;
    localparam logic [IDX_W-1:0] CTL_IDX = 6'h18;

    // ------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------
    localparam int MAIN_CLEAR_BIT = 0;
    localparam int STBY_CLEAR_BIT = 2;
    localparam int CLEAR_LOCK_BIT = 7;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

    // counter slots
    localparam int MAIN = 0;
    localparam int STBY = 1;
    localparam int NUM_COUNTERS = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 64'd40_000_000;
    localparam longint TICK_PERIOD_S = 64'd1;
    localparam int unsigned SECOND_CYCLES = int'(TICK_PERIOD_S * CLK_HZ);

    // ------------------------------------------------------------
    // bus carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avmm_req_s;

endpackage

// ### hw/second_tick_divider.sv
// Purpose: one-cycle enable pulse once every CYCLES clocks
// Assumes: single clock domain
// Notes: pulse comes from a flip-flop
`timescale 1ns/100ps
module second_tick_divider #(
    parameter int unsigned CYCLES = elapsed_timers_pkg::SECOND_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    import elapsed_timers_pkg::*;

    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } div_state_s;

    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    div_state_s st_r;
    div_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.count >= LAST) begin
            st_nxt.count = 32'h0000_0000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.count = st_r.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule

// ### hw/power_active_elapsed_timers.sv
// Purpose: main and standby power-on elapsed-time counters with byte snapshots
// Assumes: power-good inputs synchronous to clk; Avalon-MM master keeps requests stable
// Notes: every access answers with one waitrequest-low cycle after acceptance
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
module power_active_elapsed_timers #(
    parameter int unsigned SECOND_CYCLES = elapsed_timers_pkg::SECOND_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic main_power_on,
    input wire logic standby_power_on,
    input elapsed_timers_pkg::avmm_req_s bus_req,
    output logic [31:0] readdata,
    output logic waitrequest
);
    import elapsed_timers_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_COUNTERS-1:0][31:0] count;
        logic [NUM_COUNTERS-1:0][31:0] copy;
        logic [NUM_COUNTERS-1:0] frozen;
        logic lock;
        logic waitrequest;
        logic [31:0] readdata;
    } timers_state_s;

    timers_state_s st_r;
    timers_state_s st_nxt;
    logic tick;
    logic accept;
    logic rd_acc;
    logic wr_acc;
    logic [IDX_W-1:0] idx;
    logic [NUM_COUNTERS-1:0] powered;
    logic [NUM_COUNTERS-1:0] clr;

    function automatic logic hit(input logic [IDX_W-1:0] i, input logic [IDX_W-1:0] reg_idx);
        hit = (i == reg_idx);
    endfunction

    function automatic logic [31:0] byte_word(input logic [31:0] v, input int b);
        byte_word = {24'h00_0000, v[b*8 +: 8]};
    endfunction

    second_tick_divider #(
        .CYCLES(SECOND_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a request is taken only while waitrequest is high, so the answer
    // cycle itself never doubles as a second acceptance
    assign accept = (bus_req.read | bus_req.write) & st_r.waitrequest;
    assign rd_acc = accept & bus_req.read;
    assign wr_acc = accept & bus_req.write;
    assign idx = bus_req.address[ADDR_W-1:2];
    assign powered = {standby_power_on, main_power_on};

    // clear requests are dropped while the lock stands
    assign clr[MAIN] = wr_acc & hit(idx, CTL_IDX) & bus_req.byteenable[0] & ~st_r.lock
                       & bus_req.writedata[MAIN_CLEAR_BIT];
    assign clr[STBY] = wr_acc & hit(idx, CTL_IDX) & bus_req.byteenable[0] & ~st_r.lock
                       & bus_req.writedata[STBY_CLEAR_BIT];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.waitrequest = ~accept;
        for (int c = 0; c < NUM_COUNTERS; c++) begin
            // counting goes on regardless of freeze
            if (clr[c]) begin
                st_nxt.count[c] = COUNT_RESET;
            end else if (tick && powered[c]) begin
                st_nxt.count[c] = st_r.count[c] + 32'h0000_0001;
            end
            if (!st_r.frozen[c]) begin
                st_nxt.copy[c] = st_r.count[c];
            end
        end
        if (rd_acc) begin
            unique case (idx)
                MAIN_B0_IDX: begin
                    st_nxt.readdata = byte_word(st_r.copy[MAIN], 0);
                    st_nxt.frozen[MAIN] = 1'b1;
                end
                MAIN_B1_IDX: st_nxt.readdata = byte_word(st_r.copy[MAIN], 1);
                MAIN_B2_IDX: st_nxt.readdata = byte_word(st_r.copy[MAIN], 2);
                MAIN_B3_IDX: begin
                    st_nxt.readdata = byte_word(st_r.copy[MAIN], 3);
                    st_nxt.frozen[MAIN] = 1'b0;
                end
                STBY_B0_IDX: begin
                    st_nxt.readdata = byte_word(st_r.copy[STBY], 0);
                    st_nxt.frozen[STBY] = 1'b1;
                end
                STBY_B1_IDX: st_nxt.readdata = byte_word(st_r.copy[STBY], 1);
                STBY_B2_IDX: st_nxt.readdata = byte_word(st_r.copy[STBY], 2);
                STBY_B3_IDX: begin
                    st_nxt.readdata = byte_word(st_r.copy[STBY], 3);
                    st_nxt.frozen[STBY] = 1'b0;
                end
                CTL_IDX: begin
                    // clear bits are self-clearing and always read zero
                    st_nxt.readdata = ZERO_WORD;
                    st_nxt.readdata[CLEAR_LOCK_BIT] = st_r.lock;
                end
                default: st_nxt.readdata = ZERO_WORD;
            endcase
        end else if (wr_acc) begin
            st_nxt.readdata = ZERO_WORD;
            // counter bytes are read-only; only the control word takes writes
            if (hit(idx, CTL_IDX) && bus_req.byteenable[0] && !st_r.lock) begin
                st_nxt.lock = bus_req.writedata[CLEAR_LOCK_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.waitrequest <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign readdata = st_r.readdata;
    assign waitrequest = st_r.waitrequest;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence main_b0_read;
        rd_acc && idx == MAIN_B0_IDX;
    endsequence

    sequence main_b3_read;
        rd_acc && idx == MAIN_B3_IDX;
    endsequence

    sequence stby_b0_read;
        rd_acc && idx == STBY_B0_IDX;
    endsequence

    sequence answer_gap;
        !waitrequest ##1 waitrequest;
    endsequence

    count_step_a: assert property (tick && main_power_on && !clr[MAIN]
        |=> st_r.count[MAIN] == $past(st_r.count[MAIN]) + 32'h0000_0001)
        else $error("main counter did not advance on a powered second");

    count_idle_a: assert property (!tick && !clr[STBY] |=> $stable(st_r.count[STBY]))
        else $error("standby counter moved without a second tick");

    main_byte_a: assert property (rd_acc && idx == MAIN_B1_IDX
        |=> !waitrequest && readdata == {24'h00_0000, $past(st_r.copy[MAIN][15:8])})
        else $error("main byte 1 read returned wrong data");

    stby_byte_a: assert property (rd_acc && idx == STBY_B2_IDX
        |=> !waitrequest && readdata == {24'h00_0000, $past(st_r.copy[STBY][23:16])})
        else $error("standby byte 2 read returned wrong data");

    freeze_hold_a: assert property (main_b0_read ##1 !(rd_acc && idx == MAIN_B3_IDX)
        |=> $stable(st_r.copy[MAIN]))
        else $error("main copy changed while frozen");

    resume_main_a: assert property (main_b3_read |=> !st_r.frozen[MAIN] ##1
        st_r.copy[MAIN] == $past(st_r.count[MAIN]))
        else $error("main copy did not resume after highest byte read");

    read_only_a: assert property (wr_acc && idx != CTL_IDX
        |=> $stable(st_r.frozen) && $stable(st_r.lock))
        else $error("write to a read-only offset changed state");

    clear_zero_a: assert property (clr[STBY] |=> st_r.count[STBY] == COUNT_RESET)
        else $error("standby clear did not zero the counter");

    lock_hold_a: assert property (st_r.lock |-> clr == 2'b00 ##1 st_r.lock)
        else $error("lock failed to block clears or dropped");

    follow_a: assert property (!st_r.frozen[STBY] && !(rd_acc && idx == STBY_B0_IDX)
        |=> st_r.copy[STBY] == $past(st_r.count[STBY]))
        else $error("standby copy not following live count");

    // one answer cycle per request; a second low cycle would hand stale data on
    answer_once_a: assert property (accept |=> answer_gap)
        else $error("waitrequest not low for exactly one cycle");

    stby_count_a: assert property (tick && standby_power_on && !clr[STBY]
        |=> st_r.count[STBY] == $past(st_r.count[STBY]) + 32'h0000_0001)
        else $error("standby counter did not advance on a powered second");

    main_off_a: assert property (tick && !main_power_on && !clr[MAIN]
        |=> $stable(st_r.count[MAIN]))
        else $error("main counter moved without main power");

    main_b0_data_a: assert property (main_b0_read
        |=> readdata == {24'h00_0000, $past(st_r.copy[MAIN][7:0])} && st_r.frozen[MAIN])
        else $error("main byte 0 read wrong or did not freeze");

    stby_freeze_a: assert property (stby_b0_read |=> st_r.frozen[STBY])
        else $error("standby copies not frozen after byte 0 read");

    main_clear_a: assert property (clr[MAIN] |=> st_r.count[MAIN] == COUNT_RESET)
        else $error("main clear did not zero the counter");

    ctl_read_a: assert property (rd_acc && idx == CTL_IDX
        |=> readdata[MAIN_CLEAR_BIT] == 1'b0 && readdata[STBY_CLEAR_BIT] == 1'b0)
        else $error("clear bits did not read back as zero");

    lock_write_a: assert property (wr_acc && idx == CTL_IDX && !st_r.lock
        && bus_req.byteenable[0]
        |=> st_r.lock == $past(bus_req.writedata[CLEAR_LOCK_BIT]))
        else $error("unlocked control write did not store the lock bit");

    // standby highest byte resumes its copies, same as the main side
    stby_resume_a: assert property (rd_acc && idx == STBY_B3_IDX
        |=> !st_r.frozen[STBY])
        else $error("standby copies not resumed after highest byte read");

endmodule

// ### verification/power_active_elapsed_timers_tb.sv
// Purpose: self-checking bench for the power-on elapsed-time counters
// Assumes: SECOND_CYCLES shortened to 8 so one second is 8 clocks
// Notes: bus reads and writes go through one Avalon-MM task
`timescale 1ns/100ps
module power_active_elapsed_timers_tb;
    import elapsed_timers_pkg::*;
    localparam int unsigned SEC = 8;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic main_power_on = 1'b0;
    logic standby_power_on = 1'b0;
    avmm_req_s bus_req = '0;
    logic [31:0] readdata;
    logic waitrequest;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] q, v, w, m;
    row_s rows [0:11] = '{'{1'b1, 8'h40, 32'h0000_00ff, 32'h0}, '{1'b0, 8'h40, 32'h0, 32'h0},
        '{1'b1, 8'h5c, 32'h0000_00ff, 32'h0}, '{1'b0, 8'h44, 32'h0, 32'h0},
        '{1'b0, 8'h48, 32'h0, 32'h0}, '{1'b0, 8'h4c, 32'h0, 32'h0},
        '{1'b0, 8'h50, 32'h0, 32'h0}, '{1'b0, 8'h54, 32'h0, 32'h0},
        '{1'b0, 8'h58, 32'h0, 32'h0}, '{1'b0, 8'h5c, 32'h0, 32'h0},
        '{1'b0, 8'h60, 32'h0, 32'h0}, '{1'b0, 8'h7c, 32'h0, 32'h0}};

    power_active_elapsed_timers #(.SECOND_CYCLES(SEC)) dut (.clk(clk), .rst(rst),
        .main_power_on(main_power_on), .standby_power_on(standby_power_on),
        .bus_req(bus_req), .readdata(readdata), .waitrequest(waitrequest));

    // ------------------------------------------------------------
    // clock, timeout and reporting
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    // ceiling is well over ten times the expected run of about 1300 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ------------------------------------------------------------
    // bus master: hold request until waitrequest sampled low
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        bus_req.read <= ~wr;
        bus_req.write <= wr;
        bus_req.address <= a;
        bus_req.writedata <= d;
        bus_req.byteenable <= 4'hf;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        r = readdata;
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
        // idle edge keeps two calls apart
        @(posedge clk);
    endtask

    // low byte first, high byte last, so the copies are left live
    task automatic rdcnt(input logic [7:0] base, output logic [31:0] c);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, base + 8'(4 * i), 32'h0, r);
            c[8*i +: 8] = r[7:0];
        end
    endtask

    task automatic run(input logic mp, input logic sp, input int n);
        main_power_on <= mp;
        standby_power_on <= sp;
        repeat (n) @(posedge clk);
        main_power_on <= 1'b0;
        standby_power_on <= 1'b0;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].d, q);
            if (!rows[i].wr) check("reset_read", q, rows[i].e);
        end
        run(1'b1, 1'b1, 100 * SEC);
        rdcnt(8'h40, v);
        rdcnt(8'h50, w);
        check("main_count", {31'h0, v >= 32'd99 && v <= 32'd101}, 32'h1);
        check("stby_equal", w, v);
        main_power_on <= 1'b1;
        standby_power_on <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            bus(1'b0, 8'h40 + 8'(16 * k), 32'h0, q);
            repeat (10 * SEC) @(posedge clk);
            bus(1'b0, 8'h40 + 8'(16 * k), 32'h0, m);
            check("frozen_b0", m, q);
            rdcnt(8'h40 + 8'(16 * k), v);
            check("snapshot", 32'(v[7:0]), 32'(q[7:0]));
            repeat (2) @(posedge clk);
            rdcnt(8'h40 + 8'(16 * k), w);
            check("resumed", {31'h0, w >= v + 32'd10}, 32'h1);
        end
        run(1'b0, 1'b0, 2);
        rdcnt(8'h50, w);
        bus(1'b1, 8'h60, 32'h0000_0001, q);
        rdcnt(8'h40, v);
        check("main_clear", v, ZERO_WORD);
        rdcnt(8'h50, m);
        check("stby_kept", m, w);
        bus(1'b0, 8'h60, 32'h0, q);
        check("clear_reads0", q, ZERO_WORD);
        bus(1'b1, 8'h60, 32'h0000_0004, q);
        rdcnt(8'h50, m);
        check("stby_clear", m, ZERO_WORD);
        run(1'b1, 1'b0, 10 * SEC);
        rdcnt(8'h50, w);
        check("stby_unpowered", w, ZERO_WORD);
        rdcnt(8'h40, m);
        check("main_alone", {31'h0, m >= 32'd9 && m <= 32'd11}, 32'h1);
        bus(1'b1, 8'h60, 32'h0000_0080, q);
        bus(1'b1, 8'h60, 32'h0000_0001, q);
        rdcnt(8'h40, v);
        check("locked_clear", v, m);
        bus(1'b1, 8'h60, 32'h0, q);
        bus(1'b0, 8'h60, 32'h0, q);
        check("lock_held", q, 32'h0000_0080);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 8'h60, 32'h0, q);
        check("lock_reset", q, ZERO_WORD);
        rdcnt(8'h40, v);
        check("count_reset", v, COUNT_RESET);
        final_report();
    end
endmodule
